// *** escard_pkg.sv ***
// Package for the expansion slot card interface: constants and carrier types
package escard_pkg;
  // Clock and bus timing
  localparam int CLK_MHZ = 100;
  localparam int SLAVE_ASSERT_NS = 35;
  localparam int SLAVE_NEGATE_NS = 50;
  localparam int SLAVE_ASSERT_CYC = (SLAVE_ASSERT_NS * CLK_MHZ) / 1000;
  localparam int SLAVE_NEGATE_CYC = (SLAVE_NEGATE_NS * CLK_MHZ) / 1000;
  // Address map
  localparam int ADDR_W = 23;
  localparam int DATA_W = 16;
  localparam logic [23:0] CFG_BASE = 24'he80000;
  localparam logic [23:0] CFG_SIZE = 24'h010000;
  localparam logic [23:0] RESET_BASE_ADDR = 24'h200000;
  localparam logic [23:0] RESET_SIZE = 24'h010000;
  localparam logic [7:0] CFG_OFS_BASE = 8'h48;
  localparam logic [7:0] CFG_OFS_SHUTUP = 8'h4c;

  // Sampled bus inputs
  typedef struct packed {
    logic as_n;
    logic uds_n;
    logic lds_n;
    logic read;
    logic bus_error_line_n;
    logic transfer_acknowledge_n;
    logic grant_acknowledge_n;
    logic grant_n;
    logic clear_n;
    logic data_output_enable;
    logic cfg_in_n;
    logic buffered_bus_reset_n;
    logic bclk;
    logic [ADDR_W:1] addr;
    logic [DATA_W-1:0] wdata;
  } escard_bus_in_t;

  // Open-drain pin: output level and enable
  typedef struct packed {
    logic o;
    logic oe;
  } escard_od_t;

  // Arbitration states
  typedef enum logic [4:0] {
    ARB_IDLE = 5'b00001,
    ARB_REQ = 5'b00010,
    ARB_OWN = 5'b00100,
    ARB_ACK = 5'b01000,
    ARB_REL = 5'b10000
  } escard_arb_t;
endpackage

// *** escard_slot.sv ***
// Slot-side logic of an expansion card on the 16-bit legacy bus
//
// Operation
// - Bus reset returns configuration logic to unconfigured.
// - System reset pin is only pulled low or released.
// - I/O reset drives the system reset line only; full reset also pulls halt.
// - Card resets processor by driving system reset and halt together.
// - Only level-two and level-six interrupts, pulled low only.
// - Slave response within 35ns of strobe, negated within 50ns.
// - Unconfigured with chain-in asserted, respond at config window.
// - Chain-out negated at reset, asserted once configured or shut up.
// - Read data drivers enabled only while data output enable permits.
// - Bus ownership pulled low while card is master.
// - Request on system-clock rise; grant returns on a fall.
// - Ownership, then acknowledge, then drop request; release reversed.
// - Acknowledge only after grant with strobe, transfer ack, ack idle.
// - On bus clear, master gives up the bus promptly.
// - Master moves gathered data in one burst.
// - Read-enable asserted for reads, valid until cycle end.
// - Word address lines 1 to 23 span 16 megabytes.
// - Strobe fall starts cycle; rise ends it, slave releases at once.
// - Transfers delimited by address strobe and data strobes.
// - 16-bit data by word or byte, writes by data strobes.
// - Slave, read-data, ownership and acknowledge drivers float while bus error asserted.
// - Synchronous activity timed from the bus system clock; here all logic runs on clk and only the request waits for a bclk rise.
`timescale 1ns/1ps
module escard_slot
  import escard_pkg::*;
(
  // Clock, enable, reset
  input wire logic clk,
  input wire logic ce,
  input wire logic rst_n,
  // Bus pins, raw
  input wire escard_bus_in_t bus_pin,
  // Open-drain outputs
  output escard_od_t sysrst_od,
  output escard_od_t halt_od,
  output escard_od_t irq2_od,
  output escard_od_t irq6_od,
  output escard_od_t own_od,
  output escard_od_t grant_acknowledge_od,
  // Actively driven outputs
  output logic slave_n,
  output logic cfg_out_n,
  output logic bus_req_n,
  output logic [DATA_W-1:0] rdata,
  output logic rdata_oe,
  // User side
  input wire logic user_sysreset,
  input wire logic user_fullreset,
  input wire logic user_irq2,
  input wire logic user_irq6,
  input wire logic user_dma_req,
  input wire logic user_dma_done,
  input wire logic [DATA_W-1:0] user_rdata,
  input wire logic [7:0] user_board_size,
  output logic configured,
  output logic [7:0] board_base,
  output logic [ADDR_W:1] acc_addr,
  output logic [DATA_W-1:0] acc_wdata,
  output logic [1:0] acc_be,
  output logic acc_wr,
  output logic acc_rd,
  output logic master,
  output logic bus_clear_seen
);
  import escard_pkg::*;

  // Address decode, used for the config window; the board window compares addr[23:16] directly
  function automatic logic in_window(input logic [23:0] a, input logic [23:0] base, input logic [23:0] size);
    in_window = (a >= base) && (a < base + size);
  endfunction

  escard_bus_in_t s1_reg, s2_reg, s3_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= '1;
      s2_reg <= '1;
      s3_reg <= '1;
    end else if (ce) begin
      s1_reg <= bus_pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Synchronised view; s3 only for edge detection
  escard_bus_in_t b;
  assign b = s2_reg;
  logic bclk_rise;
  logic [23:0] byte_addr;
  logic strobe;
  logic data_strobe;
  assign bclk_rise = b.bclk && !s3_reg.bclk;
  assign byte_addr = {b.addr, 1'b0};
  assign strobe = !b.as_n;
  assign data_strobe = !b.uds_n || !b.lds_n;

  // Configuration and slave response state
  logic cfg_done_reg, cfg_done_next;
  logic [7:0] base_reg, base_next;
  logic slave_reg, slave_next;
  logic xfer_reg, xfer_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic [DATA_W-1:0] wdata_reg, wdata_next;
  logic [ADDR_W:1] addr_reg, addr_next;
  logic [1:0] be_reg, be_next;
  logic acc_wr_next, acc_rd_next, acc_wr_reg, acc_rd_reg;
  logic hit_cfg, hit_board, hit;

  always_comb begin
    hit_cfg = !cfg_done_reg && !b.cfg_in_n && in_window(byte_addr, CFG_BASE, CFG_SIZE);
    hit_board = cfg_done_reg && (b.addr[23:16] >= base_reg)
      && ({1'b0, b.addr[23:16]} < ({1'b0, base_reg} + {1'b0, user_board_size}));
    hit = hit_cfg || hit_board;
    cfg_done_next = cfg_done_reg;
    base_next = base_reg;
    slave_next = slave_reg;
    xfer_next = xfer_reg;
    rdata_next = rdata_reg;
    wdata_next = wdata_reg;
    addr_next = addr_reg;
    be_next = be_reg;
    acc_wr_next = 1'b0;
    acc_rd_next = 1'b0;
    // Slave response follows the strobe; sync delay is why the timing budget is tight
    if (strobe && hit && !master) begin
      slave_next = 1'b1;
    end
    if (!strobe) begin
      slave_next = 1'b0;
      xfer_next = 1'b0;
    end
    // One transfer per data strobe pulse, so locked read-modify-write splits correctly
    if (slave_reg && strobe && data_strobe && !xfer_reg) begin
      xfer_next = 1'b1;
      addr_next = b.addr;
      be_next = {!b.uds_n, !b.lds_n};
      if (b.read) begin
        acc_rd_next = 1'b1;
        rdata_next = hit_cfg ? {8'h00, base_reg} : user_rdata;
      end else begin
        acc_wr_next = 1'b1;
        wdata_next = b.wdata;
        if (hit_cfg && byte_addr[7:0] == CFG_OFS_BASE) begin
          base_next = b.wdata[15:8];
          cfg_done_next = 1'b1;
        end
        if (hit_cfg && byte_addr[7:0] == CFG_OFS_SHUTUP) begin
          cfg_done_next = 1'b1;
        end
      end
    end
    if (strobe && data_strobe == 1'b0) begin
      xfer_next = 1'b0;
    end
    if (!b.buffered_bus_reset_n) begin
      cfg_done_next = 1'b0;
      base_next = 8'h00;
      slave_next = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_done_reg <= 1'b0;
      base_reg <= 8'h00;
      slave_reg <= 1'b0;
      xfer_reg <= 1'b0;
      rdata_reg <= 16'h0000;
      wdata_reg <= 16'h0000;
      addr_reg <= '0;
      be_reg <= 2'b00;
      acc_wr_reg <= 1'b0;
      acc_rd_reg <= 1'b0;
    end else if (ce) begin
      cfg_done_reg <= cfg_done_next;
      base_reg <= base_next;
      slave_reg <= slave_next;
      xfer_reg <= xfer_next;
      rdata_reg <= rdata_next;
      wdata_reg <= wdata_next;
      addr_reg <= addr_next;
      be_reg <= be_next;
      acc_wr_reg <= acc_wr_next;
      acc_rd_reg <= acc_rd_next;
    end
  end

  // Arbitration state
  escard_arb_t arb_reg, arb_next;
  logic req_reg, req_next;
  logic own_reg, own_next;
  logic ack_reg, ack_next;
  // Acknowledge preconditions as one signal, so the check can look one cycle back
  logic grant_take;
  assign grant_take = !b.grant_n && b.as_n && b.transfer_acknowledge_n && b.grant_acknowledge_n;

  always_comb begin
    arb_next = arb_reg;
    req_next = req_reg;
    own_next = own_reg;
    ack_next = ack_reg;
    case (arb_reg)
      ARB_IDLE: begin
        if (user_dma_req && bclk_rise) begin
          req_next = 1'b1;
          arb_next = ARB_REQ;
        end
      end
      ARB_REQ: begin
        if (grant_take) begin
          own_next = 1'b1;
          arb_next = ARB_OWN;
        end
      end
      ARB_OWN: begin
        ack_next = 1'b1;
        arb_next = ARB_ACK;
      end
      ARB_ACK: begin
        req_next = 1'b0;
        // User logic bursts from its own buffer, then lets go
        if (user_dma_done || !b.clear_n) begin
          ack_next = 1'b0;
          arb_next = ARB_REL;
        end
      end
      ARB_REL: begin
        own_next = 1'b0;
        arb_next = ARB_IDLE;
      end
      default: begin
        arb_next = ARB_IDLE;
        req_next = 1'b0;
        own_next = 1'b0;
        ack_next = 1'b0;
      end
    endcase
    if (!b.buffered_bus_reset_n) begin
      arb_next = ARB_IDLE;
      req_next = 1'b0;
      own_next = 1'b0;
      ack_next = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arb_reg <= ARB_IDLE;
      req_reg <= 1'b0;
      own_reg <= 1'b0;
      ack_reg <= 1'b0;
    end else if (ce) begin
      arb_reg <= arb_next;
      req_reg <= req_next;
      own_reg <= own_next;
      ack_reg <= ack_next;
    end
  end

  // Outputs; bus error floats the slave, read-data, ownership and acknowledge drivers
  logic bus_error_line;
  assign bus_error_line = !b.bus_error_line_n;
  assign slave_n = !(slave_reg && !bus_error_line);
  assign cfg_out_n = !cfg_done_reg;
  assign bus_req_n = !req_reg;
  assign rdata = rdata_reg;
  assign rdata_oe = slave_reg && b.read && b.data_output_enable && strobe && !bus_error_line;
  assign sysrst_od = '{o: 1'b0, oe: user_sysreset || user_fullreset};
  assign halt_od = '{o: 1'b0, oe: user_fullreset};
  assign irq2_od = '{o: 1'b0, oe: user_irq2};
  assign irq6_od = '{o: 1'b0, oe: user_irq6};
  assign own_od = '{o: 1'b0, oe: own_reg && !bus_error_line};
  assign grant_acknowledge_od = '{o: 1'b0, oe: ack_reg && !bus_error_line};
  assign configured = cfg_done_reg;
  assign board_base = base_reg;
  assign acc_addr = addr_reg;
  assign acc_wdata = wdata_reg;
  assign acc_be = be_reg;
  assign acc_wr = acc_wr_reg;
  assign acc_rd = acc_rd_reg;
  assign master = ack_reg;
  assign bus_clear_seen = !b.clear_n;

  // Assertions
  sequence s_strobe_end;
    $rose(b.as_n);
  endsequence

  sequence s_strobe_start;
    $fell(b.as_n);
  endsequence

  sequence s_own_drop;
    $fell(own_reg);
  endsequence

  a_slave_release: assert property (@(posedge clk) disable iff (!rst_n)
    (ce and s_strobe_end) |=> !slave_reg) else $error("slave response held after strobe end");
  a_cfg_reset: assert property (@(posedge clk) disable iff (!rst_n)
    ce && !b.buffered_bus_reset_n |=> !cfg_done_reg) else $error("configuration kept through bus reset");
  a_chain_out: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_out_n == !cfg_done_reg) else $error("chain output mismatches state");
  a_own_before_ack: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(ack_reg) |-> $past(own_reg)) else $error("acknowledge before ownership");
  a_ack_cond: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(own_reg) |-> $past(grant_take)) else $error("took bus early");
  a_read_drive: assert property (@(posedge clk) disable iff (!rst_n)
    rdata_oe |-> b.data_output_enable && b.read) else $error("read drivers on without enable");
  a_bus_error_line_float: assert property (@(posedge clk) disable iff (!rst_n)
    bus_error_line |-> slave_n && !rdata_oe && !own_od.oe && !grant_acknowledge_od.oe) else $error("driver on during bus error");
  a_halt_pair: assert property (@(posedge clk) disable iff (!rst_n)
    halt_od.oe |-> sysrst_od.oe) else $error("halt without system reset");
  a_pull_low: assert property (@(posedge clk) disable iff (!rst_n)
    !sysrst_od.o && !halt_od.o && !irq2_od.o && !irq6_od.o && !own_od.o && !grant_acknowledge_od.o)
    else $error("open-drain line driven high");
  // Three edges from pin to response, about 30 ns here, inside the 35 ns budget
  a_slave_prompt: assert property (@(posedge clk) disable iff (!rst_n)
    s_strobe_start ##0 (ce && hit && !master && b.buffered_bus_reset_n) |=> slave_reg) else $error("slave response late");
  a_slave_hit: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(slave_reg) |-> $past(hit) && $past(strobe)) else $error("slave response without address hit");

  // Arbitration order
  a_req_rise: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(req_reg) |-> $past(bclk_rise)) else $error("request off the bus clock rise");
  a_req_drop: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(req_reg) |-> $past(ack_reg) || !$past(b.buffered_bus_reset_n)) else $error("request dropped before acknowledge");
  a_ack_hold: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(ack_reg) |-> $past(user_dma_done) || !$past(b.clear_n) || !$past(b.buffered_bus_reset_n))
    else $error("acknowledge dropped early");
  a_own_release: assert property (@(posedge clk) disable iff (!rst_n)
    s_own_drop |-> !$past(ack_reg) || !$past(b.buffered_bus_reset_n)) else $error("ownership released before acknowledge");
  // Transfer strobes last one cycle each
  a_wr_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    ce && acc_wr_reg |=> !acc_wr_reg) else $error("write strobe longer than a cycle");
  a_rd_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    ce && acc_rd_reg |=> !acc_rd_reg) else $error("read strobe longer than a cycle");
  a_cfg_window: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(cfg_done_reg) |-> $past(hit_cfg) && !$past(b.read)) else $error("configured outside the window");
endmodule

// *** escard_ctl_model.sv ***
// Bus controller model: bus system clock and slot grant
`timescale 1ns/1ps
module escard_ctl_model (
  // Clock, reset
  input wire logic clk,
  input wire logic rst_n,
  // Slot arbitration
  input wire logic bus_req_n,
  input wire logic grant_acknowledge_n,
  output logic bclk,
  output logic grant_n
);
  logic [2:0] div_reg;
  // 14 fast cycles per bus clock, close to the legacy rate
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= 3'h0;
      bclk <= 1'b0;
    end else begin
      div_reg <= (div_reg == 3'h6) ? 3'h0 : div_reg + 3'h1;
      if (div_reg == 3'h6) bclk <= ~bclk;
    end
  end
  // Grant moves only on a bus clock fall; withdrawn once acknowledged
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) grant_n <= 1'b1;
    else if (div_reg == 3'h6 && bclk) grant_n <= bus_req_n | ~grant_acknowledge_n;
  end
endmodule

// *** expansion_slot_card_interface_test.sv ***
// Self-checking bench for the expansion slot card
`timescale 1ns/1ps
module expansion_slot_card_interface_test;
  import escard_pkg::*;
  logic clk, rst_n, bclk, grant_n, dma_req, ce, clr_seen;
  escard_bus_in_t bp, pin;
  escard_od_t sysrst_od, halt_od, irq2_od, irq6_od, own_od, grant_acknowledge_od;
  logic slave_n, cfg_out_n, bus_req_n, rdata_oe, configured, master;
  logic [15:0] rdata, user_rdata, lfsr, awd;
  logic [3:0] ureq;
  logic [1:0] abe;
  logic [7:0] m_base, bbase;
  int n_errors, tests_run, i, m_cfg;

  // Wired acknowledge: the card's own pull is the only one on this bus
  always_comb begin
    pin = bp;
    pin.bclk = bclk;
    pin.grant_n = grant_n;
    pin.grant_acknowledge_n = ~grant_acknowledge_od.oe;
  end

  escard_ctl_model ctl (.clk(clk), .rst_n(rst_n), .bus_req_n(bus_req_n), .grant_acknowledge_n(pin.grant_acknowledge_n),
    .bclk(bclk), .grant_n(grant_n));

  escard_slot dut (.clk(clk), .ce(ce), .rst_n(rst_n), .bus_pin(pin), .sysrst_od(sysrst_od),
    .halt_od(halt_od), .irq2_od(irq2_od), .irq6_od(irq6_od), .own_od(own_od), .grant_acknowledge_od(grant_acknowledge_od),
    .slave_n(slave_n), .cfg_out_n(cfg_out_n), .bus_req_n(bus_req_n), .rdata(rdata), .rdata_oe(rdata_oe),
    .user_sysreset(ureq[0]), .user_fullreset(ureq[1]), .user_irq2(ureq[2]), .user_irq6(ureq[3]),
    .user_dma_req(dma_req), .user_dma_done(1'b0), .user_rdata(user_rdata), .user_board_size(8'h01),
    .configured(configured), .board_base(bbase), .acc_addr(), .acc_wdata(awd), .acc_be(abe), .acc_wr(),
    .acc_rd(), .master(master), .bus_clear_seen(clr_seen));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic tmo();
    if (i >= 80) begin
      chk("wait_bound", 16'h0, 16'h1);
      close_out();
    end
  endtask

  // One legacy cycle; entered just after a rising edge
  task automatic cyc(input logic [23:0] a, input logic rd, dv, hit, input logic [15:0] wd, ev);
    bp.addr = a[23:1];
    bp.read = rd;
    bp.data_output_enable = dv;
    bp.wdata = wd;
    bp.as_n = 1'b0;
    repeat (4) @(posedge clk);
    #1 chk("slave_on", slave_n, !hit);
    bp.uds_n = 1'b0;
    bp.lds_n = 1'b0;
    repeat (4) @(posedge clk);
    #1 chk("rdata_oe", rdata_oe, rd & dv & hit);
    if (rd && hit) chk("rdata", rdata, ev);
    bp.uds_n = 1'b1;
    bp.lds_n = 1'b1;
    bp.as_n = 1'b1;
    repeat (5) @(posedge clk);
    #1 chk("slave_off", slave_n, 1'b1);
    chk("oe_off", rdata_oe, 1'b0);
  endtask

  initial begin
    n_errors = 0;
    tests_run = 0;
    lfsr = 16'd4619;
    rst_n = 1'b0;
    bp = '1;
    bp.read = 1'b0;
    bp.data_output_enable = 1'b0;
    bp.cfg_in_n = 1'b0;
    ureq = 4'h0;
    dma_req = 1'b0;
    user_rdata = 16'h0;
    ce = 1'b1;
    m_cfg = 0;
    m_base = 8'h0;
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    chk("cfg_out_rst", cfg_out_n, 1'b1);
    chk("own_rst", own_od.oe, 1'b0);
    for (i = 0; i < 4; i++) begin
      ureq = 4'h1 << i;
      @(posedge clk);
      #1 chk("sysrst", sysrst_od.oe, ureq[0] | ureq[1]);
      chk("halt", halt_od.oe, ureq[1]);
      chk("irqs", {irq6_od.oe, irq2_od.oe}, ureq[3:2]);
      chk("od_low", sysrst_od.o | halt_od.o | irq2_od.o | irq6_od.o, 1'b0);
    end
    ureq = 4'h0;
    $display("test reset_pins done");
    cyc(CFG_BASE, 1'b1, 1'b1, 1'b1, 16'h0, {8'h00, m_base});
    cyc(CFG_BASE, 1'b1, 1'b0, 1'b1, 16'h0, 16'h0);
    cyc(24'h400000, 1'b1, 1'b1, 1'b0, 16'h0, 16'h0);
    lfsr = nxt(lfsr);
    m_base = 8'h40 + {4'h0, lfsr[3:0]};
    cyc(CFG_BASE + CFG_OFS_BASE, 1'b0, 1'b0, 1'b1, {m_base, 8'h00}, 16'h0);
    m_cfg = 1;
    chk("configured", configured, m_cfg[0]);
    chk("cfg_out", cfg_out_n, 1'b0);
    chk("board_base", bbase, m_base);
    chk("acc_wdata", awd, {m_base, 8'h00});
    chk("acc_be", abe, 2'b11);
    user_rdata = lfsr;
    cyc({m_base, 16'h0100}, 1'b1, 1'b1, 1'b1, 16'h0, user_rdata);
    cyc(CFG_BASE, 1'b1, 1'b1, 1'b0, 16'h0, 16'h0);
    $display("test configure done");
    bp.buffered_bus_reset_n = 1'b0;
    repeat (4) @(posedge clk);
    #1 bp.buffered_bus_reset_n = 1'b1;
    m_cfg = 0;
    repeat (3) @(posedge clk);
    #1 chk("unconfig", configured, m_cfg[0]);
    chk("cfg_out_clr", cfg_out_n, 1'b1);
    cyc({m_base, 16'h0100}, 1'b1, 1'b1, 1'b0, 16'h0, 16'h0);
    bp.cfg_in_n = 1'b1;
    cyc(CFG_BASE, 1'b1, 1'b1, 1'b0, 16'h0, 16'h0);
    bp.cfg_in_n = 1'b0;
    cyc(CFG_BASE + CFG_OFS_SHUTUP, 1'b0, 1'b0, 1'b1, 16'h0, 16'h0);
    chk("shut_up", cfg_out_n, 1'b0);
    ce = 1'b0;
    bp.buffered_bus_reset_n = 1'b0;
    repeat (4) @(posedge clk);
    #1 bp.buffered_bus_reset_n = 1'b1;
    repeat (3) @(posedge clk);
    #1 ce = 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("ce_freeze", cfg_out_n, 1'b0);
    $display("test chain done");
    dma_req = 1'b1;
    for (i = 0; i < 80 && own_od.oe !== 1'b1; i++) begin @(posedge clk); #1; end
    tmo();
    chk("grant_first", grant_n, 1'b0);
    chk("ack_after_own", grant_acknowledge_od.oe, 1'b0);
    chk("req_held", bus_req_n, 1'b0);
    for (i = 0; i < 80 && grant_acknowledge_od.oe !== 1'b1; i++) begin @(posedge clk); #1; end
    tmo();
    chk("req_until_ack", bus_req_n, 1'b0);
    repeat (2) @(posedge clk);
    #1 chk("req_drop", bus_req_n, 1'b1);
    chk("master", master, 1'b1);
    bp.bus_error_line_n = 1'b0;
    repeat (4) @(posedge clk);
    #1 chk("bus_error_line_float", {own_od.oe, grant_acknowledge_od.oe}, 2'b00);
    bp.bus_error_line_n = 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("bus_error_line_back", {own_od.oe, grant_acknowledge_od.oe}, 2'b11);
    dma_req = 1'b0;
    bp.clear_n = 1'b0;
    for (i = 0; i < 80 && grant_acknowledge_od.oe !== 1'b0; i++) begin @(posedge clk); #1; end
    tmo();
    chk("own_after_ack", own_od.oe, 1'b1);
    for (i = 0; i < 80 && own_od.oe !== 1'b0; i++) begin @(posedge clk); #1; end
    tmo();
    chk("ack_released", grant_acknowledge_od.oe, 1'b0);
    chk("clear_seen", clr_seen, 1'b1);
    bp.clear_n = 1'b1;
    $display("test arbitration done");
    close_out();
  end
endmodule
